/* File: cmp_far_side.sv */
// Behavioural model of the two analog comparator cores and the gate timer clock source.
`timescale 1ns/1ns
module cmp_far_side
    import cmp_pkg::*;
(
    // Clock and test controls
    input wire logic clk_sys,
    input wire logic [1:0] level,
    input wire logic timer_run,
    // Core controls from the block
    input core_ctrl_t core_ctrl_one,
    input core_ctrl_t core_ctrl_two,
    // Far side outputs
    output logic [1:0] core_raw,
    output logic timer_clk_src
);
    logic [1:0] div_q = 2'h0;
    logic tclk_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // A core that is switched off has no active output, so it reads low.
    assign core_raw = level & {core_ctrl_two.enable, core_ctrl_one.enable};

    ////////////////////////////////////////////////////////////////////////////////
    // The timer source stands still low while stopped; it runs at one eighth of clk_sys.
    always @(posedge clk_sys)
    begin
        div_q <= timer_run ? div_q + 2'h1 : 2'h0;
        if (!timer_run)
            tclk_q <= 1'b0;
        else if (div_q == 2'h3)
            tclk_q <= ~tclk_q;
    end
    assign timer_clk_src = tclk_q;
endmodule

/* File: cmp_pkg.sv */
// Package with register map, field positions and carrier types for the dual comparator control.
package cmp_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_MAIN_ONE = 3'h0;
    localparam logic [2:0] ADDR_INPUTS_ONE = 3'h1;
    localparam logic [2:0] ADDR_MAIN_TWO = 3'h2;
    localparam logic [2:0] ADDR_INPUTS_TWO = 3'h3;
    localparam logic [2:0] ADDR_MIRROR = 3'h4;
    localparam logic [2:0] ADDR_FLAGS = 3'h5;
    // Main control register fields.
    localparam int BIT_ON = 7;
    localparam int BIT_RESULT = 6;
    localparam int BIT_PIN_DRIVE = 5;
    localparam int BIT_INVERT = 4;
    localparam int BIT_SPEED = 2;
    localparam int BIT_HYST = 1;
    localparam int BIT_SYNC = 0;
    // Input control register fields.
    localparam int BIT_RISE_EN = 7;
    localparam int BIT_FALL_EN = 6;
    localparam int PLUS_LO = 4;
    localparam int MINUS_LO = 0;
    localparam logic [7:0] MAIN_WMASK = 8'hb7;
    localparam logic [7:0] INPUTS_WMASK = 8'hf3;
    localparam logic [7:0] MAIN_RESET = 8'h04;
    localparam logic [7:0] INPUTS_RESET = 8'h00;
    localparam logic [1:0] PLUS_PIN = 2'h0;
    localparam logic [1:0] PLUS_DAC = 2'h1;
    localparam logic [1:0] PLUS_FIXED = 2'h2;
    localparam logic [1:0] PLUS_ALT = 2'h3;

    typedef struct packed {
        logic [7:0] main;
        logic [7:0] inputs;
    } cmp_cfg_t;

    // Controls to one analog core.
    typedef struct packed {
        logic enable;
        logic high_speed;
        logic hysteresis;
        logic [1:0] plus_sel;
        logic [1:0] minus_sel;
        logic plus_to_ground;
    } core_ctrl_t;
endpackage

/* File: dual_comparator_control.sv */
// Register file, polarity, synchronisation, output routing and edge flags for two comparators.
`timescale 1ns/1ns

// Notes on behaviour
// [R1] comparator_on enables the core; cleared means the core is off.
// [R2] comparator_result reads the post-polarity compare outcome, read only.
// [R3] result_pin_drive routes the result to the pin, ignoring comparator_on.
// [R4] result_invert inverts the core output before reporting and use.
// [R5] speed_power_select resets to 1 for normal speed; 0 selects low power.
// [R6] hysteresis_enable drives the core hysteresis control.
// [R7] With sync set, timer and pin output update on timer clock falling edge.
// [R8] With sync clear, timer and pin output follow the result unlatched.
// [R9] rise_flag_enable lets a rising result edge set the event flag.
// [R10] fall_flag_enable lets a falling result edge set the event flag.
// [R11] plus_input_select picks pin, DAC, fixed reference, or shared pin/ground.
// [R12] minus_input_select picks one of four shared minus pins.
// [R13] Mirror register holds both results in bits 1..0; unused bits read 0.
// [R14] Internal result is latched once per cycle; outside outputs are not.
// [R15] Software clears the flag; an edge in the same cycle keeps it set.
// [R16] Edge detection follows the post-polarity result even when disabled.
// [R17] Pin drive overrides the port latch regardless of comparator_on.
// [R18] Raw core output passes a two-stage synchroniser before edge detection.
module dual_comparator_control
    import cmp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog cores and companion timer
    input wire logic [1:0] core_raw,
    input wire logic timer_clk_src,
    output core_ctrl_t core_ctrl_one,
    output core_ctrl_t core_ctrl_two,
    // Outputs to the gate timer, the pins and the event flags
    output logic [1:0] timer_gate_out,
    output logic [1:0] pin_out,
    output logic [1:0] pin_override,
    output logic [1:0] event_flag
);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    cmp_cfg_t cfg_q [2];
    cmp_cfg_t cfg_d [2];
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] flag_q, flag_d;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            cfg_d[i] = cfg_q[i];
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_MAIN_ONE: cfg_d[0].main = reg_wdata & MAIN_WMASK;
                ADDR_INPUTS_ONE: cfg_d[0].inputs = reg_wdata & INPUTS_WMASK;
                ADDR_MAIN_TWO: cfg_d[1].main = reg_wdata & MAIN_WMASK;
                ADDR_INPUTS_TWO: cfg_d[1].inputs = reg_wdata & INPUTS_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 2; i++)
            begin
                cfg_q[i].main <= MAIN_RESET; // [R5]
                cfg_q[i].inputs <= INPUTS_RESET;
            end
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result path: synchroniser, polarity, per-cycle latch, edge detection.
    // The analog output is asynchronous, so only sync2 feeds any logic.
    logic [1:0] sync1_q, sync2_q, res_q, res_d;
    logic [1:0] post_pol, rise, fall, pin_q, pin_d, gate_q, gate_d, ovr_q, ovr_d;
    logic tclk_q;
    logic tfall;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            // A disabled core gives a low raw level; polarity still applies.
            post_pol[i] = (sync2_q[i] & cfg_q[i].main[BIT_ON]) // [R1]
                ^ cfg_q[i].main[BIT_INVERT]; // [R4] [R16]
        end
        res_d = post_pol; // [R14]
        rise = res_d & ~res_q;
        fall = ~res_d & res_q;
        tfall = tclk_q & ~timer_clk_src;
        flag_d = flag_q;
        for (int i = 0; i < 2; i++)
        begin
            if (reg_wr && reg_addr == ADDR_FLAGS && !reg_wdata[i])
            begin
                flag_d[i] = 1'b0;
            end
            if ((rise[i] && cfg_q[i].inputs[BIT_RISE_EN]) // [R9]
                || (fall[i] && cfg_q[i].inputs[BIT_FALL_EN])) // [R10]
            begin
                flag_d[i] = 1'b1; // [R15]
            end
        end
        gate_d = gate_q;
        for (int i = 0; i < 2; i++)
        begin
            if (!cfg_q[i].main[BIT_SYNC])
            begin
                gate_d[i] = post_pol[i]; // [R8]
            end
            else if (tfall)
            begin
                gate_d[i] = post_pol[i]; // [R7]
            end
            ovr_d[i] = cfg_q[i].main[BIT_PIN_DRIVE]; // [R3] [R17]
        end
        pin_d = gate_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            res_q <= 2'h0;
            flag_q <= 2'h0;
            gate_q <= 2'h0;
            pin_q <= 2'h0;
            ovr_q <= 2'h0;
            tclk_q <= 1'b0;
        end
        else
        begin
            sync1_q <= core_raw; // [R18]
            sync2_q <= sync1_q;
            res_q <= res_d;
            flag_q <= flag_d;
            gate_q <= gate_d;
            pin_q <= pin_d;
            ovr_q <= ovr_d;
            tclk_q <= timer_clk_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core controls and read port.
    core_ctrl_t ctl_d [2];
    core_ctrl_t ctl_q [2];

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            ctl_d[i].enable = cfg_q[i].main[BIT_ON]; // [R1]
            ctl_d[i].high_speed = cfg_q[i].main[BIT_SPEED]; // [R5]
            ctl_d[i].hysteresis = cfg_q[i].main[BIT_HYST]; // [R6]
            ctl_d[i].plus_sel = cfg_q[i].inputs[PLUS_LO+:2]; // [R11]
            ctl_d[i].minus_sel = cfg_q[i].inputs[MINUS_LO+:2]; // [R12]
            ctl_d[i].plus_to_ground = (i == 1) && (ctl_d[i].plus_sel == PLUS_ALT); // [R11]
        end
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_MAIN_ONE: rdata_d = cfg_q[0].main | {1'b0, res_q[0], 6'h00}; // [R2]
                ADDR_INPUTS_ONE: rdata_d = cfg_q[0].inputs;
                ADDR_MAIN_TWO: rdata_d = cfg_q[1].main | {1'b0, res_q[1], 6'h00}; // [R2]
                ADDR_INPUTS_TWO: rdata_d = cfg_q[1].inputs;
                ADDR_MIRROR: rdata_d = {6'h00, res_q}; // [R13]
                ADDR_FLAGS: rdata_d = {6'h00, flag_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rdata_q <= 8'h00;
            for (int i = 0; i < 2; i++)
            begin
                ctl_q[i] <= '0;
                // The core must see the reset speed setting while reset is held.
                ctl_q[i].high_speed <= MAIN_RESET[BIT_SPEED]; // [R5]
            end
        end
        else
        begin
            rdata_q <= rdata_d;
            ctl_q <= ctl_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign core_ctrl_one = ctl_q[0];
    assign core_ctrl_two = ctl_q[1];
    assign timer_gate_out = gate_q;
    assign pin_out = pin_q;
    assign pin_override = ovr_q;
    assign event_flag = flag_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    AST_RISE_SETS: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R9]
        (rise[0] && cfg_q[0].inputs[BIT_RISE_EN]) |=> event_flag[0])
        else $error("rising edge did not set flag");
    AST_FALL_SETS: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R10]
        (fall[0] && cfg_q[0].inputs[BIT_FALL_EN]) |=> event_flag[0])
        else $error("falling edge did not set flag");
    AST_NO_FLAG: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R9]
        (!flag_q[0] && !cfg_q[0].inputs[BIT_RISE_EN] && !cfg_q[0].inputs[BIT_FALL_EN])
        |=> !event_flag[0])
        else $error("flag set with edges disabled");
    AST_CLEAR_LOSES: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R15]
        (reg_wr && reg_addr == ADDR_FLAGS && rise[0] && cfg_q[0].inputs[BIT_RISE_EN])
        |=> event_flag[0])
        else $error("edge lost during clear");
    AST_SYNC_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R7]
        (cfg_q[1].main[BIT_SYNC] && !tfall) |=> $stable(timer_gate_out[1]))
        else $error("synced output moved without timer falling edge");
    AST_ASYNC_FOLLOW: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R8]
        !cfg_q[0].main[BIT_SYNC] |=> timer_gate_out[0] == $past(post_pol[0]))
        else $error("unsynced output did not follow");
    AST_MIRROR: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R13]
        (reg_rd && reg_addr == ADDR_MIRROR) |=> reg_rdata == {6'h00, $past(res_q)})
        else $error("mirror read wrong");
    AST_SYNC_PATH: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R18]
        (cfg_q[1].main[BIT_ON] && !cfg_q[1].main[BIT_INVERT]) ##1
        (cfg_q[1].main[BIT_ON] && !cfg_q[1].main[BIT_INVERT]) |-> res_d[1] == $past(core_raw[1], 2))
        else $error("result not two stages behind core");
    AST_SPEED_RESET: assert property (@(posedge clk_sys) // [R5]
        $rose(reset_n) |-> cfg_q[0].main[BIT_SPEED] && cfg_q[1].main[BIT_SPEED])
        else $error("speed bit not set after reset");
    COV_FLAG: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(event_flag[0]));
    COV_SYNC: cover property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_q[1].main[BIT_SYNC] && tfall);
    COV_CLEAR: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(event_flag[0]));
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the dual comparator control block.
`timescale 1ns/1ns
module tb_top;
    import cmp_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] core_raw, timer_gate_out, pin_out, pin_override, event_flag;
    logic [1:0] level = 2'h0;
    logic timer_clk_src;
    logic timer_run = 1'b0;
    core_ctrl_t core_ctrl_one, core_ctrl_two;
    int fail_count = 0;
    int tests_run = 0;

    always #5 clk_sys = ~clk_sys;

    dual_comparator_control i_dual_comparator_control (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .core_raw(core_raw), .timer_clk_src(timer_clk_src),
        .core_ctrl_one(core_ctrl_one), .core_ctrl_two(core_ctrl_two),
        .timer_gate_out(timer_gate_out), .pin_out(pin_out), .pin_override(pin_override),
        .event_flag(event_flag));
    cmp_far_side i_cmp_far_side (.clk_sys(clk_sys), .level(level), .timer_run(timer_run),
        .core_ctrl_one(core_ctrl_one), .core_ctrl_two(core_ctrl_two), .core_raw(core_raw),
        .timer_clk_src(timer_clk_src));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [2:0] a, input string what, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // Result and flag both need three edges; six leaves margin.
    task automatic settle;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(ADDR_MAIN_ONE, "main one", MAIN_RESET);
        rd(ADDR_INPUTS_TWO, "inputs two", 8'h00);
        rd(ADDR_MIRROR, "mirror", 8'h00);
        rd(3'h7, "unmapped", 8'h00);
        chk("high speed", 8'h01, {7'h0, core_ctrl_two.high_speed});
        $display("reset test done");
    endtask

    task automatic t_edges;
        wr(ADDR_INPUTS_ONE, 8'h80);
        wr(ADDR_MAIN_ONE, 8'hfa);
        rd(ADDR_MAIN_ONE, "main one rb", 8'hf2);
        chk("flag on invert", 8'h01, {6'h0, event_flag});
        wr(ADDR_MAIN_ONE, 8'h86);
        wr(ADDR_FLAGS, 8'h00);
        settle();
        chk("ctl one", 8'h03, {6'h0, core_ctrl_one.enable, core_ctrl_one.hysteresis});
        chk("flag cleared", 8'h00, {6'h0, event_flag});
        level <= 2'h1;
        // The clear is timed to land on the very edge at which the result rises.
        @(posedge clk_sys);
        wr(ADDR_FLAGS, 8'h00);
        settle();
        rd(ADDR_MAIN_ONE, "result", 8'hc6);
        rd(ADDR_MIRROR, "mirror one", 8'h01);
        chk("rise flag", 8'h01, {6'h0, event_flag});
        chk("gate unsynced", 8'h01, {6'h0, timer_gate_out});
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_INPUTS_ONE, 8'h40);
        wr(ADDR_MAIN_ONE, 8'h06);
        settle();
        rd(ADDR_MAIN_ONE, "disabled", 8'h06);
        chk("fall flag", 8'h01, {6'h0, event_flag});
        $display("edge test done");
    endtask

    task automatic t_inputs;
        logic [7:0] v;
        for (int p = 0; p < 4; p++)
        begin
            v = {2'h0, p[1:0], 2'h0, p[1:0]};
            wr(ADDR_INPUTS_ONE, v);
            wr(ADDR_INPUTS_TWO, v);
            @(posedge clk_sys);
            #1;
            chk("routing", {2'h0, 1'b0, p == 3, p[1:0], p[1:0]}, {2'h0,
                core_ctrl_one.plus_to_ground, core_ctrl_two.plus_to_ground,
                core_ctrl_two.plus_sel, core_ctrl_two.minus_sel});
            chk("routing one", {4'h0, p[1:0], p[1:0]}, {4'h0,
                core_ctrl_one.plus_sel, core_ctrl_one.minus_sel});
            rd(ADDR_INPUTS_TWO, "inputs rb", v);
        end
        $display("input select test done");
    endtask

    task automatic t_sync;
        wr(ADDR_MAIN_TWO, 8'ha5);
        level <= 2'h3;
        settle();
        chk("pin drive", 8'h02, {6'h0, pin_override});
        chk("gate held", 8'h00, {7'h0, timer_gate_out[1]});
        timer_run <= 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        chk("gate synced", 8'h01, {7'h0, timer_gate_out[1]});
        chk("pin synced", 8'h01, {7'h0, pin_out[1]});
        $display("sync test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_edges();
        t_inputs();
        t_sync();
        close_out();
    end

    // The whole run takes about 130 cycles, so two thousand means a hang.
    initial
    begin
        #20000;
        fail_count++;
        close_out();
    end
endmodule
